// File: epiv_pkg.sv
package epiv_pkg;

  // ---------------------------------------------------------------------------
  // Register map, word aligned byte addresses.
  // ---------------------------------------------------------------------------
  localparam logic [3:0] ADDR_CORE_CONTROL  = 4'h0;
  localparam logic [3:0] ADDR_IRQ_ENABLE    = 4'h4;
  localparam logic [3:0] ADDR_FLAGS         = 4'h8;
  localparam logic [3:0] ADDR_MASK_LO       = 4'hC;
  localparam logic [3:0] ADDR_MASK_HI       = 4'h0;
  localparam logic [3:0] ADDR_VECTOR        = 4'h4;
  localparam logic       PAGE_LO            = 1'b0;
  localparam logic       PAGE_HI            = 1'b1;

  // ---------------------------------------------------------------------------
  // Field positions.
  // ---------------------------------------------------------------------------
  localparam int SENSE_LO_BIT   = 0;
  localparam int SENSE_HI_BIT   = 1;
  localparam int GLOBAL_EN_BIT  = 7;
  localparam int EXT_BIT        = 6;
  localparam int PC_HI_BIT      = 5;
  localparam int PC_LO_BIT      = 4;

  // ---------------------------------------------------------------------------
  // Sense select encodings and vector addresses.
  // ---------------------------------------------------------------------------
  localparam logic [1:0] SENSE_LOW     = 2'h0;
  localparam logic [1:0] SENSE_ANY     = 2'h1;
  localparam logic [1:0] SENSE_FALL    = 2'h2;
  localparam logic [1:0] SENSE_RISE    = 2'h3;

  localparam logic [4:0] VEC_RESET     = 5'h00;
  localparam logic [4:0] VEC_EXT       = 5'h01;
  localparam logic [4:0] VEC_PC_LO     = 5'h02;
  localparam logic [4:0] VEC_PC_HI     = 5'h03;
  localparam logic [4:0] VEC_WDT       = 5'h04;
  localparam logic [4:0] VEC_PERIPH0   = 5'h05;
  localparam int         PERIPH_COUNT  = 12;
  localparam logic [4:0] VEC_LAST      = 5'h10;

  localparam logic [7:0] ZERO_BYTE     = 8'h00;
  localparam logic [7:0] RESET_BYTE    = 8'h00;

endpackage

// File: epiv_top.sv
`timescale 1ns/1ps
//
// Contract
// - All reset sources send program flow to vector address 0x0000.
// - External pin 0x0001, group lo 0x0002, group hi 0x0003, watchdog 0x0004.
// - Twelve peripheral sources map in order onto 0x0005 through 0x0010.
// - Enabled pin requests fire even when the pin is driven as output.
// - Any unmasked toggle on inputs 7:0 raises the low group request.
// - Any unmasked toggle on inputs 11:8 raises the high group request.
// - Per-pin mask bits, one register per group; masked pins never request.
// - Pin changes are detected without a running I/O clock.
// - External pin sensed on falling edge, rising edge, any change or low level.
// - Low-level mode keeps requesting for as long as the pin is low.
// - Edges on the external pin are recognised only while the clock runs.
// - A low level on the external pin is detected without the clock.
// - Wake on low level interrupts only if the level lasts through start-up.
// - Level gone before wake completes: no vector, resume after sleep.
// - Sense select: 00 low, 01 any change, 10 falling, 11 rising.
// - Pending flags set on request; cleared on handler entry or write one.
// - External pending flag stays clear while low-level sensing is chosen.
// - Pin vectoring needs both its enable bit and global enable set; watchdog and peripheral requests need only global enable.
//
module epiv_top (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        ext_request_pin,
  input  wire logic [11:0] pin_change_inputs,
  input  wire logic        wdt_request,
  input  wire logic [11:0] periph_requests,
  input  wire logic        startup_done,
  input  wire logic        vector_ack,
  output logic             irq_valid,
  output logic      [4:0]  irq_vector,
  output logic             wake_request,
  output logic             reg_page
);

  // ---------------------------------------------------------------------------
  // State.
  // ---------------------------------------------------------------------------
  // The control and page registers both keep the page select in their top bit.
  localparam int GLOBAL_PAGE_BIT = 7;

  logic [1:0]  sense;
  logic        global_en;
  logic [2:0]  en;            // Bit 2 ext, bit 1 group hi, bit 0 group lo.
  logic [2:0]  flag;
  logic [7:0]  mask_lo;
  logic [3:0]  mask_hi;
  logic        ext_s1;
  logic        ext_s2;
  logic        ext_prev;
  logic [11:0] pc_s1;
  logic [11:0] pc_s2;
  logic [11:0] pc_prev;
  logic        ack_pending;
  logic [1:0]  next_sense;
  logic        next_global_en;
  logic [2:0]  next_en;
  logic [2:0]  next_flag;
  logic [7:0]  next_mask_lo;
  logic [3:0]  next_mask_hi;
  logic        next_reg_page;
  logic [31:0] next_readdata;
  logic        next_waitrequest;
  logic        next_ack_pending;
  logic        next_irq_valid;
  logic [4:0]  next_irq_vector;
  logic        next_wake;

  // ---------------------------------------------------------------------------
  // Event detection.
  // ---------------------------------------------------------------------------
  logic        ext_edge;
  logic        ext_low_live;
  logic        ext_level_req;
  logic        pc_lo_hit;
  logic        pc_hi_hit;
  logic [11:0] pc_toggle;
  logic        do_write;
  logic        do_read;

  // Synchronisers; first stages feed only the second stages.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_s1   <= 1'b1;
      ext_s2   <= 1'b1;
      ext_prev <= 1'b1;
      pc_s1    <= 12'h000;
      pc_s2    <= 12'h000;
      pc_prev  <= 12'h000;
    end else begin
      ext_s1   <= ext_request_pin;
      ext_s2   <= ext_s1;
      ext_prev <= ext_s2;
      pc_s1    <= pin_change_inputs;
      pc_s2    <= pc_s1;
      pc_prev  <= pc_s2;
    end
  end

  // Edges need clocked samples; the pin value is used regardless of pin direction.
  always_comb begin
    case (sense)
      epiv_pkg::SENSE_ANY:  ext_edge = ext_s2 ^ ext_prev;
      epiv_pkg::SENSE_FALL: ext_edge = ext_prev & ~ext_s2;
      epiv_pkg::SENSE_RISE: ext_edge = ~ext_prev & ext_s2;
      default:              ext_edge = 1'b0;
    endcase
  end

  // The low level is taken from the raw pin for wake so no clock is needed;
  // the vectoring request uses the synchronised level, so a level that is gone
  // by the end of start-up produces a wake but no vector.
  assign ext_low_live  = (sense == epiv_pkg::SENSE_LOW) && !ext_request_pin;
  assign ext_level_req = (sense == epiv_pkg::SENSE_LOW) && !ext_s2 && startup_done;

  // Toggle compare on synchronised samples, gated by the per-pin masks.
  assign pc_toggle = pc_s2 ^ pc_prev;
  assign pc_lo_hit = |(pc_toggle[7:0] & mask_lo);
  assign pc_hi_hit = |(pc_toggle[11:8] & mask_hi);

  assign do_write = avs_write && !avs_waitrequest && avs_byteenable[0];
  // Read data load on the wait-state edge, so they already stand when waitrequest is sampled low.
  assign do_read  = avs_read && avs_waitrequest;

  // ---------------------------------------------------------------------------
  // Register file and flags.
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [7:0] wd;
    logic [2:0] clr;
    wd               = avs_writedata[7:0];
    clr              = 3'b000;
    next_sense       = sense;
    next_global_en   = global_en;
    next_en          = en;
    next_mask_lo     = mask_lo;
    next_mask_hi     = mask_hi;
    next_reg_page    = reg_page;
    next_readdata    = 32'h00000000;
    // One wait cycle per access keeps the answer a single registered cycle.
    next_waitrequest = !((avs_read || avs_write) && avs_waitrequest);
    if (do_write) begin
      case ({reg_page, avs_address})
        {epiv_pkg::PAGE_LO, epiv_pkg::ADDR_CORE_CONTROL}: begin
          next_sense    = wd[epiv_pkg::SENSE_HI_BIT:epiv_pkg::SENSE_LO_BIT];
          next_reg_page = wd[GLOBAL_PAGE_BIT];
        end
        {epiv_pkg::PAGE_LO, epiv_pkg::ADDR_IRQ_ENABLE}: begin
          next_global_en = wd[epiv_pkg::GLOBAL_EN_BIT];
          next_en        = {wd[epiv_pkg::EXT_BIT], wd[epiv_pkg::PC_HI_BIT], wd[epiv_pkg::PC_LO_BIT]};
        end
        {epiv_pkg::PAGE_LO, epiv_pkg::ADDR_FLAGS}: begin
          clr = {wd[epiv_pkg::EXT_BIT], wd[epiv_pkg::PC_HI_BIT], wd[epiv_pkg::PC_LO_BIT]};
        end
        {epiv_pkg::PAGE_LO, epiv_pkg::ADDR_MASK_LO}: next_mask_lo = wd;
        {epiv_pkg::PAGE_HI, epiv_pkg::ADDR_MASK_HI}: next_mask_hi = wd[3:0];
        {epiv_pkg::PAGE_HI, epiv_pkg::ADDR_FLAGS}: next_reg_page = wd[GLOBAL_PAGE_BIT];
        default: ;
      endcase
    end
    if (do_read) begin
      case ({reg_page, avs_address})
        {epiv_pkg::PAGE_LO, epiv_pkg::ADDR_CORE_CONTROL}:
          next_readdata[7:0] = {reg_page, 5'h00, sense};
        {epiv_pkg::PAGE_LO, epiv_pkg::ADDR_IRQ_ENABLE}:
          next_readdata[7:0] = {global_en, en, 4'h0};
        {epiv_pkg::PAGE_LO, epiv_pkg::ADDR_FLAGS}:
          next_readdata[7:0] = {1'b0, flag, 4'h0};
        {epiv_pkg::PAGE_LO, epiv_pkg::ADDR_MASK_LO}:
          next_readdata[7:0] = mask_lo;
        {epiv_pkg::PAGE_HI, epiv_pkg::ADDR_MASK_HI}:
          next_readdata[7:0] = {4'h0, mask_hi};
        {epiv_pkg::PAGE_HI, epiv_pkg::ADDR_VECTOR}:
          next_readdata[7:0] = {3'h0, irq_vector};
        {epiv_pkg::PAGE_HI, epiv_pkg::ADDR_FLAGS}:
          next_readdata[7:0] = {reg_page, 7'h00};
        default: next_readdata = 32'h00000000;
      endcase
    end
    // Hardware set beats both clears; handler entry clears the acknowledged flag.
    if (ack_pending && vector_ack) begin
      case (irq_vector)
        epiv_pkg::VEC_EXT:   clr[2] = 1'b1;
        epiv_pkg::VEC_PC_HI: clr[1] = 1'b1;
        epiv_pkg::VEC_PC_LO: clr[0] = 1'b1;
        default: ;
      endcase
    end
    next_flag[0] = pc_lo_hit | (flag[0] & ~clr[0]);
    next_flag[1] = pc_hi_hit | (flag[1] & ~clr[1]);
    next_flag[2] = (next_sense != epiv_pkg::SENSE_LOW) &&
                   (ext_edge | (flag[2] & ~clr[2]));
  end

  // ---------------------------------------------------------------------------
  // Priority vectoring and wake.
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [16:0] req;
    req       = {periph_requests, wdt_request, flag[1] & en[1], flag[0] & en[0],
                 (flag[2] | ext_level_req) & en[2], 1'b0};
    next_irq_valid   = 1'b0;
    next_irq_vector  = epiv_pkg::VEC_RESET;
    next_ack_pending = ack_pending && !vector_ack;
    if (global_en && !(ack_pending && vector_ack)) begin
      for (int i = epiv_pkg::PERIPH_COUNT + 4; i >= 1; i--) begin
        if (req[i]) begin
          next_irq_valid  = 1'b1;
          next_irq_vector = 5'(i);
        end
      end
    end
    if (next_irq_valid) begin
      next_ack_pending = 1'b1;
    end
    // Wake paths use raw pins and masks so no clock edge is needed.
    next_wake = ext_low_live | |((pin_change_inputs ^ pc_s2) & {mask_hi, mask_lo}) | |flag;
  end

  // Registers for all state groups other than the synchronisers.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sense           <= epiv_pkg::SENSE_LOW;
      global_en       <= 1'b0;
      en              <= 3'b000;
      flag            <= 3'b000;
      mask_lo         <= epiv_pkg::RESET_BYTE;
      mask_hi         <= 4'h0;
      reg_page        <= epiv_pkg::PAGE_LO;
      avs_readdata    <= 32'h00000000;
      avs_waitrequest <= 1'b1;
      ack_pending     <= 1'b0;
      irq_valid       <= 1'b0;
      irq_vector      <= epiv_pkg::VEC_RESET;
      wake_request    <= 1'b0;
    end else begin
      sense           <= next_sense;
      global_en       <= next_global_en;
      en              <= next_en;
      flag            <= next_flag;
      mask_lo         <= next_mask_lo;
      mask_hi         <= next_mask_hi;
      reg_page        <= next_reg_page;
      avs_readdata    <= next_readdata;
      avs_waitrequest <= next_waitrequest;
      ack_pending     <= next_ack_pending;
      irq_valid       <= next_irq_valid;
      irq_vector      <= next_irq_vector;
      wake_request    <= next_wake;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------------------
  property p_ext_clear_low;
    @(posedge clk) disable iff (!reset_n) sense == epiv_pkg::SENSE_LOW |-> ##1 !flag[2] || sense != epiv_pkg::SENSE_LOW;
  endproperty
  a_ext_clear_low: assert property (p_ext_clear_low) else $error("ext flag set in low mode");

  property p_pc_lo_set;
    @(posedge clk) disable iff (!reset_n) pc_lo_hit |=> flag[0];
  endproperty
  a_pc_lo_set: assert property (p_pc_lo_set) else $error("group lo flag missed");

  property p_pc_hi_set;
    @(posedge clk) disable iff (!reset_n) pc_hi_hit |=> flag[1];
  endproperty
  a_pc_hi_set: assert property (p_pc_hi_set) else $error("group hi flag missed");

  property p_masked;
    @(posedge clk) disable iff (!reset_n) ((pc_toggle[7:0] & mask_lo) == 8'h00 && !flag[0]) |=> !flag[0];
  endproperty
  a_masked: assert property (p_masked) else $error("masked pin set flag");

  property p_global;
    @(posedge clk) disable iff (!reset_n) !global_en |=> !irq_valid;
  endproperty
  a_global: assert property (p_global) else $error("vector without global enable");

  property p_prio;
    @(posedge clk) disable iff (!reset_n) (global_en && flag[0] && en[0] && !ack_pending && !ext_level_req
      && !(flag[2] && en[2])) |=> irq_valid && irq_vector == epiv_pkg::VEC_PC_LO;
  endproperty
  a_prio: assert property (p_prio) else $error("priority order wrong");

  property p_fall;
    @(posedge clk) disable iff (!reset_n) (sense == epiv_pkg::SENSE_FALL && ext_prev && !ext_s2) |=> flag[2];
  endproperty
  a_fall: assert property (p_fall) else $error("falling edge missed");

  property p_sync;
    @(posedge clk) disable iff (!reset_n) ext_s2 == $past(ext_request_pin, 2) || $past(!reset_n, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("synchroniser depth wrong");

  property p_range;
    @(posedge clk) disable iff (!reset_n) irq_valid |-> irq_vector >= epiv_pkg::VEC_EXT && irq_vector <= epiv_pkg::VEC_LAST;
  endproperty
  a_range: assert property (p_range) else $error("vector out of range");

  c_ext: cover property (@(posedge clk) disable iff (!reset_n) irq_valid && irq_vector == epiv_pkg::VEC_EXT);
  c_pclo: cover property (@(posedge clk) disable iff (!reset_n) irq_valid && irq_vector == epiv_pkg::VEC_PC_LO);
  c_last: cover property (@(posedge clk) disable iff (!reset_n) irq_valid && irq_vector == epiv_pkg::VEC_LAST);
  c_wake: cover property (@(posedge clk) disable iff (!reset_n) wake_request);

endmodule

// File: epiv_cpu_model.sv
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// Core model that enters handlers for presented vectors.
// -----------------------------------------------------------------------------
module epiv_cpu_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       take_en,
  input  wire logic [3:0] delay,
  input  wire logic       irq_valid,
  input  wire logic [4:0] irq_vector,
  output logic            vector_ack,
  output logic            took,
  output logic      [4:0] took_vec
);
  logic [3:0] wait_cnt;
  logic [1:0] hold;

  // The ack is a one-cycle pulse; two idle cycles follow so the request that is
  // still dropping is never entered twice.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vector_ack <= 1'b0;
      took_vec   <= 5'h00;
      wait_cnt   <= 4'h0;
      hold       <= 2'h0;
    end else if (vector_ack) begin
      vector_ack <= 1'b0;
      hold       <= 2'h2;
    end else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end else if (irq_valid && take_en) begin
      if (wait_cnt == delay) begin
        vector_ack <= 1'b1;
        took_vec   <= irq_vector;
        wait_cnt   <= 4'h0;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end

  // The handler entry is reported for the whole ack cycle.
  assign took = vector_ack;
endmodule

// File: ext_pin_interrupt_vectoring_tb_top.sv
`timescale 1ns/1ps
module ext_pin_interrupt_vectoring_tb_top;
  logic        clk, reset_n, rd, wr, pin, wdt, sdone, take_en, ack, irq_valid;
  logic        wake, page, waitreq, took, lvl_mode, e;
  logic [3:0]  addr, dly, mh;
  logic [31:0] wdata, rdata;
  logic [11:0] pc, per;
  logic [4:0]  vec, took_vec;
  logic [7:0]  m;
  int          err_count, samples_checked, cycles, seed, lvl_takes, n;
  int          exp_q[$];

  epiv_top dut_u (.clk(clk), .reset_n(reset_n), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_byteenable(4'hF), .avs_readdata(rdata), .avs_waitrequest(waitreq),
    .ext_request_pin(pin), .pin_change_inputs(pc), .wdt_request(wdt), .periph_requests(per),
    .startup_done(sdone), .vector_ack(ack), .irq_valid(irq_valid), .irq_vector(vec),
    .wake_request(wake), .reg_page(page));
  epiv_cpu_model cpu_u (.clk(clk), .reset_n(reset_n), .take_en(take_en), .delay(dly), .irq_valid(irq_valid),
    .irq_vector(vec), .vector_ack(ack), .took(took), .took_vec(took_vec));

  // -----------------------------------------------------------------------------
  // Checking and bus tasks.
  // -----------------------------------------------------------------------------
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test();
    if (err_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // The request stands until waitrequest is sampled low at a rising edge; read data are taken at that edge.
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge clk);
    rd    <= !w;
    wr    <= w;
    addr  <= a;
    wdata <= {24'h000000, d};
    do @(posedge clk); while (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input string what, input logic [3:0] a, input logic [31:0] x);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    cmp(what, x, q);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic drain();
    for (n = 0; n < 400 && exp_q.size() != 0; n++) @(posedge clk);
    cmp("vectors left", 0, exp_q.size());
  endtask

  // Clock, and a cycle ceiling that cuts a hang short.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end

  // Each handler entry is checked against the expected queue, or against vector 0x01 in level mode; the bench then
  // clears the watchdog or peripheral request the way a peripheral clears on handler entry.
  always @(posedge clk) begin
    if (took === 1'b1) begin
      if (lvl_mode) begin
        cmp("level vector", 5'h01, took_vec);
        lvl_takes++;
      end else if (exp_q.size() == 0) begin
        cmp("vector", 32'hFFFFFFFF, took_vec);
      end else begin
        cmp("vector", exp_q.pop_front(), took_vec);
      end
      if (took_vec == 5'h04) wdt <= 1'b0;
      if (took_vec >= 5'h05 && took_vec <= 5'h10) per[took_vec-5'h05] <= 1'b0;
    end
  end

  // -----------------------------------------------------------------------------
  // Main sequence.
  // -----------------------------------------------------------------------------
  initial begin
    seed = 68117;
    {reset_n, rd, wr, wdt, take_en, lvl_mode} = 6'h00;
    {pin, sdone} = 2'h3;
    {addr, dly, pc, per, wdata} = 0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    cmp("vector in reset", 5'h00, {irq_valid, vec});
    @(posedge clk);
    reset_n <= 1'b1;
    for (int a = 0; a < 16; a += 4) rdc("reset value", 4'(a), 0);
    wr8(4'h4, 8'hFF);
    rdc("enable", 4'h4, 32'h000000F0);
    m  = 8'($random(seed));
    mh = 4'($random(seed)) | 4'h1;
    wr8(4'h4, 8'h00);
    wr8(4'hC, m);
    wr8(4'h0, 8'h80);
    wr8(4'h0, {4'h0, mh});
    cmp("page", 1, page);
    rdc("mask hi", 4'h0, {28'h0, mh});
    wr8(4'hC, 8'hFF);
    rdc("unmapped", 4'hC, 0);
    rdc("current vector", 4'h4, 0);
    wr8(4'h8, 8'h00);
    rdc("control", 4'h0, 0);
    cmp("page back", 0, page);
    rdc("mask lo", 4'hC, {24'h0, m});
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      pc[i] <= ~pc[i];
      cyc(6);
      e = (i < 8) ? m[i] : mh[i-8];
      rdc("pin flags", 4'h8, {25'h0, 1'b0, e & (i >= 8), e & (i < 8), 4'h0});
      cmp("wake", e, wake);
      wr8(4'h8, 8'h30);
      rdc("flags cleared", 4'h8, 0);
    end
    wr8(4'hC, 8'hFF);
    wr8(4'h4, 8'h30);
    @(posedge clk);
    pc[0] <= ~pc[0];
    cyc(6);
    cmp("irq without global", 0, irq_valid);
    exp_q.push_back(2);
    take_en <= 1'b1;
    wr8(4'h4, 8'hB0);
    drain();
    rdc("flag after entry", 4'h8, 0);
    take_en <= 1'b0;
    wr8(4'h4, 8'h00);
    for (int s = 1; s < 4; s++) begin
      wr8(4'h0, 8'(s));
      wr8(4'h8, 8'h70);
      pin <= 1'b0;
      cyc(6);
      rdc("fall flag", 4'h8, (s == 1 || s == 2) ? 32'h40 : 0);
      wr8(4'h8, 8'h40);
      pin <= 1'b1;
      cyc(6);
      rdc("rise flag", 4'h8, (s == 1 || s == 3) ? 32'h40 : 0);
    end
    @(posedge clk);
    pc[0] <= ~pc[0];
    pc[8] <= ~pc[8];
    wdt   <= 1'b1;
    per   <= 12'hFFF;
    cyc(6);
    for (int v = 1; v <= 16; v++) exp_q.push_back(v);
    dly     <= 4'h3;
    take_en <= 1'b1;
    wr8(4'h4, 8'hF0);
    drain();
    cyc(6);
    cmp("idle after drain", 0, irq_valid);
    wr8(4'h0, 8'h00);
    wr8(4'h4, 8'hC0);
    dly      <= 4'h0;
    lvl_mode <= 1'b1;
    sdone    <= 1'b0;
    pin      <= 1'b0;
    cyc(6);
    cmp("low wake", 1, wake);
    rdc("level flag", 4'h8, 0);
    pin <= 1'b1;
    cyc(4);
    sdone <= 1'b1;
    cyc(10);
    cmp("level gone takes", 0, lvl_takes);
    pin <= 1'b0;
    cyc(30);
    pin <= 1'b1;
    cyc(10);
    cmp("level retrigger", 1, lvl_takes >= 2);
    lvl_mode <= 1'b0;
    cyc(2);
    reset_n <= 1'b0;
    cyc(2);
    cmp("vector in second reset", 0, {irq_valid, vec, wake});
    reset_n <= 1'b1;
    rdc("enable after reset", 4'h4, 0);
    cyc(2);
    stop_test();
  end
endmodule
